/* common/clh_pkg.sv */
package clh_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TEST_TIME_NS  = 1000;
  localparam int TEST_CYCLES   =
    (TEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXEC_TIME_NS  = 2000;
  localparam int EXEC_CYCLES   =
    (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] NUM_TESTS  = 4'hF;
  localparam logic [3:0] FIRST_SHOWN = 4'h6;

  // ---------------------------------------------------------------
  // register map and flag bits
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_FLAG  = 8'h00;
  localparam logic [7:0] OFF_CMAR  = 8'h04;
  localparam logic [7:0] OFF_CMD_DATA_LOW_REG = 8'h08;
  localparam logic [7:0] OFF_CMD_DATA_HIGH_REG = 8'h0C;
  localparam int FB_IE         = 6;
  localparam int FB_RESET      = 9;
  localparam int FB_GO         = 10;
  localparam int FB_LIST_VALID = 12;
  localparam int FB_NEW_CMD    = 13;
  localparam int FB_RESP_READY = 14;
  localparam int FB_SKIP       = 15;

  // ---------------------------------------------------------------
  // self-test result codes
  // ---------------------------------------------------------------
  localparam logic [15:0] ST_PASS = 16'hAAAA;
  localparam logic [15:0] ST_FAIL = 16'h5555;
  localparam logic [15:0] ST_SKIP = 16'h55AA;

  // ---------------------------------------------------------------
  // command block layout (word index pointers, zero is null)
  // ---------------------------------------------------------------
  localparam int BLK_LIST_END  = 31;
  localparam int BLK_RESP_DONE = 30;
  localparam logic [15:0] NULL_PTR = 16'h0000;

  typedef enum logic [3:0] {
    E_IDLE  = 4'h0,
    E_INIT  = 4'h1,
    E_FETCH = 4'h2,
    E_LINK  = 4'h3,
    E_EXEC  = 4'h4,
    E_RESP  = 4'h5,
    E_RLINK = 4'h6,
    E_RCLR  = 4'h7
  } clh_eng_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_TEST = 2'h1,
    S_DONE = 2'h2
  } clh_st_t;
endpackage : clh_pkg

/* src/clh_cmd_mem.sv */
module clh_cmd_mem
  import clh_pkg::*;
#(
  parameter int AW = 6
)(
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire logic          we,
  input  wire logic [1:0]    be,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  input  wire logic [AW-1:0] raddr_a,
  output logic      [31:0]   rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [31:0]   rdata_b0,
  output logic      [31:0]   rdata_b1
);
  logic [31:0] mem [2**AW];

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 2**AW; i++)
        mem[i] <= 32'h00000000;
    end
    else if (we)
    begin
      if (be[0])
        mem[waddr][15:0] <= wdata[15:0];
      if (be[1])
        mem[waddr][31:16] <= wdata[31:16];
    end
  end

  assign rdata_a  = mem[raddr_a];
  assign rdata_b0 = mem[raddr_b];
  assign rdata_b1 = mem[raddr_b + AW'(1)];
endmodule : clh_cmd_mem

/* src/clh_selftest.sv */
module clh_selftest
  import clh_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        run,
  input  wire logic        skip,
  input  wire logic        fault,
  input  wire logic [3:0]  fault_test,
  output logic             done,
  output logic             lo_we,
  output logic             hi_we,
  output logic      [15:0] lo_val,
  output logic      [15:0] hi_val
);
  clh_st_t     st;
  logic [3:0]  tnum;
  logic [15:0] cnt;

  assign done = (st == S_DONE);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st     <= S_IDLE;
      tnum   <= 4'h0;
      cnt    <= 16'h0000;
      lo_we  <= 1'b0;
      hi_we  <= 1'b0;
      lo_val <= 16'h0000;
      hi_val <= 16'h0000;
    end
    else
    begin
      lo_we <= 1'b0;
      hi_we <= 1'b0;
      case (st)
        S_IDLE:
        begin
          if (run && skip)
          begin
            st     <= S_DONE;
            lo_we  <= 1'b1;
            hi_we  <= 1'b1;
            lo_val <= ST_SKIP;
            hi_val <= 16'h0000;
          end
          else if (run)
          begin
            st   <= S_TEST;
            tnum <= 4'h1;
            cnt  <= 16'h0000;
          end
        end
        S_TEST:
        begin
          cnt <= cnt + 16'h0001;
          // progress marker lets software see where a hang happened
          if (cnt == 16'h0000 && tnum >= FIRST_SHOWN)
          begin
            hi_we  <= 1'b1;
            hi_val <= {4'h0, tnum, 8'h00};
          end
          if (cnt == 16'(TEST_CYCLES - 1))
          begin
            cnt <= 16'h0000;
            if (fault && fault_test == tnum)
            begin
              st     <= S_DONE;
              lo_we  <= 1'b1;
              hi_we  <= 1'b1;
              lo_val <= ST_FAIL;
              hi_val <= {4'h0, tnum, tnum, 4'h0};
            end
            else if (tnum == NUM_TESTS)
            begin
              st     <= S_DONE;
              lo_we  <= 1'b1;
              hi_we  <= 1'b1;
              lo_val <= ST_PASS;
              hi_val <= 16'h0000;
            end
            else
              tnum <= tnum + 4'h1;
          end
        end
        S_DONE:
          st <= S_IDLE;
        default:
          st <= S_IDLE;
      endcase
    end
  end
endmodule : clh_selftest

/* src/clh_host_if.sv */
// Local design decisions: register access over AHB-Lite and the register addresses.
module clh_host_if
  import clh_pkg::*;
#(
  parameter int AW = 6
)(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        st_fault,
  input  wire logic [3:0]  st_fault_test,
  output logic             resp_irq
);
  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic       dp_wr, dp_rd, rd_wait;
  logic [7:0] dp_addr;
  logic       ap_valid, wr_fire, wr_flag;

  assign ap_valid  = hsel && htrans[1] && hready;
  // one wait state on reads; hrdata is taken in the first data cycle, so a load just queued by a CMAR write is not yet seen
  assign hreadyout = !(dp_rd && !rd_wait);
  assign hresp     = 1'b0;
  assign wr_fire   = dp_wr;
  assign wr_flag   = wr_fire && dp_addr == OFF_FLAG;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      rd_wait <= 1'b0;
      dp_addr <= 8'h00;
    end
    else if (ap_valid)
    begin
      dp_wr   <= hwrite && hsize == 3'h2;
      dp_rd   <= !hwrite;
      rd_wait <= 1'b0;
      dp_addr <= haddr[7:0];
    end
    else if (hready)
    begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
    end
    else if (dp_rd)
      rd_wait <= 1'b1;
  end

  // ---------------------------------------------------------------
  // flag and data registers
  // ---------------------------------------------------------------
  logic          rst_bit, go, list_valid, new_cmd, resp_ready, ie, skip;
  logic [AW-1:0] cmar;
  logic [15:0]   cmd_data_low_reg, cmd_data_high_reg;
  logic          ld_pend, take_cmd, take_list, resp_evt;
  logic          st_done, st_lo_we, st_hi_we;
  logic [15:0]   st_lo, st_hi;
  logic [31:0]   rdata_a, rdata_b0, rdata_b1;
  logic [15:0]   flag_word;

  assign flag_word = {1'b0, resp_ready, new_cmd, list_valid, 1'b0, go,
                      rst_bit, 2'b00, ie, 6'h00};
  assign resp_irq  = resp_ready && ie;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      OFF_FLAG:  rd_mux = {16'h0000, flag_word};
      OFF_CMAR:  rd_mux = {{(32 - AW){1'b0}}, cmar};
      OFF_CMD_DATA_LOW_REG: rd_mux = {16'h0000, cmd_data_low_reg};
      OFF_CMD_DATA_HIGH_REG: rd_mux = {16'h0000, cmd_data_high_reg};
      default:   rd_mux = 32'h00000000;
    endcase
  endfunction : rd_mux

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      hrdata <= 32'h00000000;
    else if (dp_rd && !rd_wait)
      hrdata <= rd_mux(dp_addr);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_bit <= 1'b1;
    // a host restart landing on the done cycle wins over the clear
    else if (wr_flag && hwdata[FB_RESET])
      rst_bit <= 1'b1;
    else if (st_done)
      rst_bit <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      skip <= 1'b0;
    else if (wr_flag && hwdata[FB_RESET] && !rst_bit)
      skip <= hwdata[FB_SKIP];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      go         <= 1'b0;
      ie         <= 1'b0;
      list_valid <= 1'b0;
      new_cmd    <= 1'b0;
      resp_ready <= 1'b0;
    end
    else
    begin
      if (wr_flag)
      begin
        go <= hwdata[FB_GO];
        ie <= hwdata[FB_IE];
      end
      // hardware-set and host-set flags: the set wins over the clear
      if (wr_flag && hwdata[FB_LIST_VALID])
        list_valid <= 1'b1;
      else if (take_list)
        list_valid <= 1'b0;
      if (wr_flag && hwdata[FB_NEW_CMD])
        new_cmd <= 1'b1;
      else if (take_cmd)
        new_cmd <= 1'b0;
      if (resp_evt)
        resp_ready <= 1'b1;
      else if (wr_flag && hwdata[FB_RESP_READY])
        resp_ready <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmar    <= '0;
      cmd_data_low_reg   <= 16'h0000;
      cmd_data_high_reg   <= 16'h0000;
      ld_pend <= 1'b0;
    end
    else
    begin
      ld_pend <= wr_fire && dp_addr == OFF_CMAR;
      if (wr_fire && dp_addr == OFF_CMAR)
        cmar <= hwdata[AW-1:0];
      if (st_lo_we)
        cmd_data_low_reg <= st_lo;
      else if (ld_pend)
        cmd_data_low_reg <= rdata_a[15:0];
      else if (wr_fire && dp_addr == OFF_CMD_DATA_LOW_REG)
        cmd_data_low_reg <= hwdata[15:0];
      if (st_hi_we)
        cmd_data_high_reg <= st_hi;
      else if (ld_pend)
        cmd_data_high_reg <= rdata_a[31:16];
      else if (wr_fire && dp_addr == OFF_CMD_DATA_HIGH_REG)
        cmd_data_high_reg <= hwdata[15:0];
    end
  end

  clh_selftest u_selftest (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .run        (rst_bit),
    .skip       (skip),
    .fault      (st_fault),
    .fault_test (st_fault_test),
    .done       (st_done),
    .lo_we      (st_lo_we),
    .hi_we      (st_hi_we),
    .lo_val     (st_lo),
    .hi_val     (st_hi)
  );

  // ---------------------------------------------------------------
  // command list engine
  // ---------------------------------------------------------------
  clh_eng_t      st;
  logic [AW-1:0] cur, nxt, last_cmd, resp_last, rblk;
  logic [AW-1:0] q_head [4];
  logic [AW-1:0] q_tail [4];
  logic [3:0]    q_valid;
  logic [1:0]    fq, xq;
  logic [15:0]   xcnt;
  logic          e_we, e_go, bus_mem_we, is_final;
  logic [1:0]    e_be;
  logic [AW-1:0] e_addr, e_raddr;
  logic [31:0]   e_wdata;

  function automatic logic [1:0] pick(input logic [3:0] v);
    pick = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
  endfunction : pick

  assign bus_mem_we = wr_fire && dp_addr == OFF_CMD_DATA_HIGH_REG;
  assign e_go       = !(e_we && bus_mem_we);
  assign take_cmd   = st == E_IDLE && go && !rst_bit && new_cmd;
  assign take_list  = take_cmd && list_valid;
  assign resp_evt   = st == E_RCLR && e_go && !rst_bit;
  assign is_final   = rblk == last_cmd && rdata_b0[15:0] == NULL_PTR;

  always_comb
  begin
    e_we    = 1'b0;
    e_be    = 2'b10;
    e_addr  = rblk;
    e_wdata = 32'h00000000;
    e_raddr = cur;
    case (st)
      E_IDLE:  e_raddr = last_cmd;
      E_INIT:  e_raddr = '0;
      E_LINK:
      begin
        e_we    = 1'b1;
        e_addr  = q_tail[fq];
        e_wdata = {16'(cur), 16'h0000};
      end
      E_EXEC:  e_raddr = rblk;
      E_RESP:
      begin
        e_raddr = rblk;
        e_we    = 1'b1;
        e_addr  = rblk + AW'(1);
        e_wdata = {is_final, 1'b1, rdata_b1[29:16], 16'h0000};
      end
      E_RLINK:
      begin
        e_we    = 1'b1;
        e_addr  = resp_last;
        e_wdata = {16'(rblk), 16'h0000};
      end
      E_RCLR:  e_we = 1'b1;
      default: e_we = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st        <= E_IDLE;
      cur       <= '0;
      nxt       <= '0;
      last_cmd  <= '0;
      resp_last <= '0;
      rblk      <= '0;
      fq        <= 2'd0;
      xq        <= 2'd0;
      xcnt      <= 16'h0000;
      q_valid   <= 4'h0;
      for (int i = 0; i < 4; i++)
      begin
        q_head[i] <= '0;
        q_tail[i] <= '0;
      end
    end
    else if (rst_bit)
    begin
      // response list restarts only here, never on a new command list
      st        <= E_IDLE;
      q_valid   <= 4'h0;
      last_cmd  <= '0;
      resp_last <= '0;
    end
    else if (e_go)
    begin
      case (st)
        E_IDLE:
        begin
          if (take_list)
            st <= E_INIT;
          else if (take_cmd && last_cmd != '0 &&
                   rdata_b0[15:0] != NULL_PTR)
          begin
            cur <= rdata_b0[AW-1:0];
            st  <= E_FETCH;
          end
          else if (go && q_valid != 4'h0)
          begin
            xq   <= pick(q_valid);
            rblk <= q_head[pick(q_valid)];
            xcnt <= 16'h0000;
            st   <= E_EXEC;
          end
        end
        E_INIT:
        begin
          cur <= rdata_b0[AW-1:0];
          st  <= rdata_b0[15:0] == NULL_PTR ? E_IDLE : E_FETCH;
        end
        E_FETCH:
        begin
          fq       <= rdata_b1[1:0];
          nxt      <= rdata_b0[AW-1:0];
          last_cmd <= cur;
          if (q_valid[rdata_b1[1:0]])
            st <= E_LINK;
          else
          begin
            q_valid[rdata_b1[1:0]] <= 1'b1;
            q_head[rdata_b1[1:0]]  <= cur;
            q_tail[rdata_b1[1:0]]  <= cur;
            cur <= rdata_b0[AW-1:0];
            st  <= rdata_b0[15:0] == NULL_PTR ? E_IDLE : E_FETCH;
          end
        end
        E_LINK:
        begin
          q_tail[fq] <= cur;
          cur        <= nxt;
          st         <= nxt == '0 ? E_IDLE : E_FETCH;
        end
        E_EXEC:
        begin
          xcnt <= xcnt + 16'h0001;
          if (xcnt == 16'(EXEC_CYCLES - 1))
            st <= E_RESP;
        end
        E_RESP:
        begin
          if (q_tail[xq] == rblk)
            q_valid[xq] <= 1'b0;
          else
            q_head[xq] <= rdata_b0[16 +: AW];
          st <= E_RLINK;
        end
        E_RLINK: st <= E_RCLR;
        E_RCLR:
        begin
          resp_last <= rblk;
          st        <= E_IDLE;
        end
        default: st <= E_IDLE;
      endcase
    end
  end

  clh_cmd_mem #(.AW(AW)) u_mem (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .we       (bus_mem_we || e_we),
    .be       (bus_mem_we ? 2'b11 : e_be),
    .waddr    (bus_mem_we ? cmar : e_addr),
    .wdata    (bus_mem_we ? {hwdata[15:0], cmd_data_low_reg} : e_wdata),
    .raddr_a  (cmar),
    .rdata_a  (rdata_a),
    .raddr_b  (e_raddr),
    .rdata_b0 (rdata_b0),
    .rdata_b1 (rdata_b1)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_rst_set;
    wr_flag && hwdata[FB_RESET] |=> rst_bit;
  endproperty
  a_rst_set: assert property (p_rst_set)
    else $error("reset bit not set by host write");

  property p_rst_clear;
    st_done && !(wr_flag && hwdata[FB_RESET]) |=>
      !rst_bit && (cmd_data_low_reg == ST_PASS || cmd_data_low_reg == ST_FAIL ||
                   cmd_data_low_reg == ST_SKIP);
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("self-test end without code or reset bit clear");

  property p_skip_code;
    rst_bit && skip && st == E_IDLE ##1 st_done |=> cmd_data_low_reg == ST_SKIP;
  endproperty
  a_skip_code: assert property (p_skip_code)
    else $error("skipped self-test did not report skip code");

  property p_fail_hi;
    st_done && st_lo == ST_FAIL |=> cmd_data_low_reg == ST_FAIL && cmd_data_high_reg[7:0] != 8'h00;
  endproperty
  a_fail_hi: assert property (p_fail_hi)
    else $error("failure reported without error number");

  property p_go_start;
    st != E_IDLE && $past(st) == E_IDLE && !$past(rst_bit) |-> $past(go);
  endproperty
  a_go_start: assert property (p_go_start)
    else $error("engine left idle without go bit");

  property p_list_start;
    take_list && !bus_mem_we |=>
      st == E_INIT ##1 rst_bit || cur == $past(rdata_b0[AW-1:0]);
  endproperty
  a_list_start: assert property (p_list_start)
    else $error("list start not fetched");

  property p_no_link_low;
    e_we && !bus_mem_we |=>
      u_mem.mem[$past(e_addr)][15:0] == $past(u_mem.mem[e_addr][15:0]);
  endproperty
  a_no_link_low: assert property (p_no_link_low)
    else $error("engine wrote a command list link");

  property p_resp_flag;
    resp_evt |=> resp_ready && resp_last == $past(rblk);
  endproperty
  a_resp_flag: assert property (p_resp_flag)
    else $error("response not flagged or not made last");
endmodule : clh_host_if

/* sim/clh_host_model.sv */
module clh_host_model
  import clh_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // single-word bus master
  // ---------------------------------------------------------------
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // sampling right after the edge sees pre-edge values, so no race
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
    // released data lines must not keep looking valid
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : clh_host_model

/* sim/clh_host_if_tb.sv */
module clh_host_if_tb
  import clh_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        st_fault;
  logic [3:0]  st_fault_test;
  logic        resp_irq;
  int          err_count;
  int          compares;

  clh_host_if #(.AW(6)) clh_host_if_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .st_fault(st_fault), .st_fault_test(st_fault_test),
    .resp_irq(resp_irq)
  );

  clh_host_model clh_host_model_i (
    .sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata)
  );

  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    clh_host_model_i.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    clh_host_model_i.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rdc

  // only the flag register is touched while init may be processing_go_bit
  task automatic poll(input int b, input logic v);
    logic [31:0] q;
    int          n;
    n = 0;
    do
    begin
      clh_host_model_i.xfer(1'b0, OFF_FLAG, 32'h0000_0000, q);
      n++;
    end
    while (q[b] !== v && n < 500);
    chk({31'h0, q[b]}, {31'h0, v});
  endtask : poll

  task automatic mw(input logic [5:0] i, input logic [31:0] d);
    wr(OFF_CMAR, {26'h0, i});
    wr(OFF_CMD_DATA_LOW_REG, {16'h0, d[15:0]});
    wr(OFF_CMD_DATA_HIGH_REG, {16'h0, d[31:16]});
  endtask : mw

  task automatic mr(input logic [5:0] i, input logic [31:0] exp);
    wr(OFF_CMAR, {26'h0, i});
    rdc(OFF_CMD_DATA_LOW_REG, {16'h0, exp[15:0]});
    rdc(OFF_CMD_DATA_HIGH_REG, {16'h0, exp[31:16]});
  endtask : mr

  // ---------------------------------------------------------------
  // clock, reset, watchdog
  // ---------------------------------------------------------------
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  initial
  begin
    #3000000;
    err_count++;
    summarize();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    err_count     = 0;
    compares      = 0;
    reset_n       = 1'b0;
    st_fault      = 1'b0;
    st_fault_test = 4'h0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    poll(FB_RESET, 1'b1);
    poll(FB_RESET, 1'b0);
    rdc(OFF_CMD_DATA_LOW_REG, 32'h0000_AAAA);
    rdc(OFF_CMD_DATA_HIGH_REG, 32'h0000_0000);
    rdc(8'h40, 32'h0000_0000);
    chk({31'h0, hresp}, 32'h0000_0000);
    // two blocks on different queues, list start 2, response link 0
    mw(6'h00, 32'h0000_0002);
    mw(6'h02, 32'h0000_0004);
    mw(6'h03, 32'h0000_0000);
    mw(6'h04, 32'h0000_0000);
    mw(6'h05, 32'h0000_0001);
    mw(6'h08, 32'h0000_0000);
    mw(6'h09, 32'h0000_0001);
    wr(OFF_FLAG, 32'h0000_0440);
    wr(OFF_FLAG, 32'h0000_3440);
    // block 8 appended behind block 4 while block 2 still executes
    mw(6'h04, 32'h0000_0008);
    wr(OFF_FLAG, 32'h0000_2440);
    poll(FB_RESP_READY, 1'b1);
    chk({31'h0, resp_irq}, 32'h0000_0001);
    wr(OFF_FLAG, 32'h0000_4440);
    poll(FB_RESP_READY, 1'b1);
    wr(OFF_FLAG, 32'h0000_4440);
    poll(FB_RESP_READY, 1'b1);
    wr(OFF_FLAG, 32'h0000_4440);
    mr(6'h00, 32'h0002_0002);
    mr(6'h02, 32'h0004_0004);
    mr(6'h03, 32'h4000_0000);
    mr(6'h04, 32'h0008_0008);
    mr(6'h05, 32'h4000_0001);
    mr(6'h08, 32'h0000_0000);
    mr(6'h09, 32'hC000_0001);
    // new list; response link left as the device set it
    mw(6'h06, 32'h0000_0000);
    mw(6'h07, 32'h0000_0002);
    mw(6'h00, 32'h0002_0006);
    wr(OFF_FLAG, 32'h0000_3440);
    poll(FB_RESP_READY, 1'b1);
    wr(OFF_FLAG, 32'h0000_4440);
    // the clear lands on the edge the write ends; look one edge later
    @(posedge sys_clk);
    chk({31'h0, resp_irq}, 32'h0000_0000);
    mr(6'h08, 32'h0006_0000);
    mr(6'h07, 32'hC000_0002);
    mr(6'h06, 32'h0000_0000);
    // failing self-test at test 7, then a skipped one
    st_fault      <= 1'b1;
    st_fault_test <= 4'h7;
    wr(OFF_FLAG, 32'h0000_0200);
    poll(FB_RESET, 1'b1);
    poll(FB_RESET, 1'b0);
    rdc(OFF_CMD_DATA_LOW_REG, 32'h0000_5555);
    rdc(OFF_CMD_DATA_HIGH_REG, 32'h0000_0770);
    st_fault <= 1'b0;
    wr(OFF_FLAG, 32'h0000_8200);
    poll(FB_RESET, 1'b0);
    rdc(OFF_CMD_DATA_LOW_REG, 32'h0000_55AA);
    rdc(OFF_CMD_DATA_HIGH_REG, 32'h0000_0000);
    summarize();
  end
endmodule : clh_host_if_tb
